/* File: hw/gmp_pkg.sv */
// shared constants, header table and character helpers of the message parser
package gmp_pkg;
	localparam logic [7:0] CH_LF    = 8'h0a;
	localparam logic [7:0] CH_CR    = 8'h0d;
	localparam logic [7:0] CH_SP    = 8'h20;
	localparam logic [7:0] CH_QUOTE = 8'h22;
	localparam logic [7:0] CH_PCT   = 8'h25;
	localparam logic [7:0] CH_PLUS  = 8'h2b;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_MINUS = 8'h2d;
	localparam logic [7:0] CH_DOT   = 8'h2e;
	localparam logic [7:0] CH_COLON = 8'h3a;
	localparam logic [7:0] CH_SEMI  = 8'h3b;
	localparam logic [7:0] CH_QMARK = 8'h3f;
	localparam logic [7:0] CH_E     = 8'h45;
	localparam logic [7:0] CH_ONES  = 8'hff;

	localparam int HDR_NUM   = 5;
	localparam int HDR_CHARS = 8;
	localparam int HIW       = $clog2(HDR_NUM);
	typedef logic [HIW-1:0] gmp_hidx_type;
	// entry 0 is the last one listed
	localparam logic [HDR_NUM-1:0][8*HDR_CHARS-1:0] HDR_NAME =
		{"CURVE   ", "SETUP   ", "TEXT    ", "LEVEL   ", "MODE    "};
	localparam logic [HDR_NUM-1:0][3:0] HDR_FULL = {4'h5, 4'h5, 4'h4, 4'h5, 4'h4};
	localparam logic [HDR_NUM-1:0][3:0] HDR_MIN  = {4'h3, 4'h3, 4'h4, 4'h3, 4'h3};
	localparam logic [HDR_NUM-1:0] HDR_LOCAL = 5'h03;
	localparam logic [HDR_NUM-1:0][31:0] HDR_LO =
		{32'h0, 32'h0, 32'h0, 32'hffff_fff6, 32'h0};
	localparam logic [HDR_NUM-1:0][31:0] HDR_HI =
		{32'h0, 32'h0, 32'h0, 32'h0000_000a, 32'h0000_0003};

	localparam logic [2:0] ERR_NONE     = 3'h0;
	localparam logic [2:0] ERR_HEADER   = 3'h1;
	localparam logic [2:0] ERR_SYNTAX   = 3'h2;
	localparam logic [2:0] ERR_RANGE    = 3'h3;
	localparam logic [2:0] ERR_CHECKSUM = 3'h4;

	localparam logic [7:0] EXP_DIG_MAX  = 8'h0a;
	localparam logic [7:0] FRAC_MAX     = 8'h64;
	localparam int         OBUF_DEPTH_DEF = 512;

	function automatic logic [7:0] upcase(input logic [7:0] c);
		return (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
	endfunction
	function automatic logic is_letter(input logic [7:0] c);
		return upcase(c) >= 8'h41 && upcase(c) <= 8'h5a;
	endfunction
	function automatic logic is_digit(input logic [7:0] c);
		return c >= 8'h30 && c <= 8'h39;
	endfunction
	function automatic logic [35:0] mul10(input logic [31:0] m);
		return ({4'h0, m} << 3) + ({4'h0, m} << 1);
	endfunction
endpackage

/* File: hw/gmp_hdr_match.sv */
// case-blind header matcher accepting abbreviated labels
`timescale 1ns/100ps
`default_nettype none
module gmp_hdr_match
	import gmp_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         clear,
	input  wire logic         char_valid,
	input  wire logic [7:0]   char_in,
	output logic              hit,
	output gmp_hidx_type      hit_idx
);
	typedef struct packed {
		logic [HDR_NUM-1:0] alive;
		logic [3:0]         cnt;
	} gmp_hm_type;

	gmp_hm_type st_reg;
	gmp_hm_type st_next;

	always_comb begin
		st_next = st_reg;
		if (clear) begin
			st_next.alive = '1;
			st_next.cnt = 4'h0;
		end else if (char_valid) begin
			for (int i = 0; i < HDR_NUM; i++) begin
				if (st_reg.cnt >= HDR_FULL[i] ||
					upcase(char_in) != HDR_NAME[i][8*HDR_CHARS-1-8*st_reg.cnt[2:0] -: 8]) begin
					st_next.alive[i] = 1'b0;
				end
			end
			if (st_reg.cnt != 4'hf) begin
				st_next.cnt = st_reg.cnt + 4'h1;
			end
		end
	end

	// a label matches from its required prefix up to its full length
	always_comb begin
		hit = 1'b0;
		hit_idx = '0;
		for (int i = HDR_NUM - 1; i >= 0; i--) begin
			if (st_reg.alive[i] && st_reg.cnt >= HDR_MIN[i] && st_reg.cnt <= HDR_FULL[i]) begin
				hit = 1'b1;
				hit_idx = gmp_hidx_type'(i);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= '{alive: '1, cnt: 4'h0};
		end else begin
			st_reg <= st_next;
		end
	end
endmodule // gmp_hdr_match
`default_nettype wire

/* File: hw/gmp_parser.sv */
// device-dependent message parser, executor hand-off and output buffer
// Function
// - header letters match regardless of upper or lower case
// - abbreviated headers accepted once the required leading characters are present
// - units split on semicolon; trailing semicolon optional
// - message ends on EOI with last byte or on LF, per switch
// - space, CR and LF between elements are skipped
// - a unit is decoded only after its delimiter or terminator
// - commands conflicting with local control are discarded while local
// - units execute one at a time in arrival order
// - space separates header from arguments; commas separate arguments
// - numbers accepted as integer, with decimal point, or scientific
// - out-of-range numbers block execution and raise an error
// - in-range numbers truncate downward to a whole setting
// - linked argument is a word, colon, then a second argument
// - quoted text is passed on as one string argument
// - binary block: percent, two-byte count, data, checksum
// - block sum after percent, checksum included, must be zero mod 256
// - query responses are placed in the output buffer
// - several responses are joined into one output message
// - output runs while talked until empty or DCL, UNT, IFC
// - output buffer emptied on DCL, or SDC or new message when listened
// - completed output ends with EOI on last byte or a trailing LF
// - response bytes that do not fit the buffer are dropped
// - talked with empty buffer sends all-ones byte with EOI
// - device clear empties buffers but never aborts an executing unit
`timescale 1ns/100ps
`default_nettype none
module gmp_parser
	import gmp_pkg::*;
#(
	parameter int OBUF_DEPTH = OBUF_DEPTH_DEF
) (
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire logic          term_sel_lf,
	input  wire logic          local_lock,
	input  wire logic          listen,
	input  wire logic          talk,
	input  wire logic          dcl,
	input  wire logic          sdc,
	input  wire logic          unt,
	input  wire logic          ifc,
	input  wire logic          rx_valid,
	input  wire logic [7:0]    rx_data,
	input  wire logic          rx_eoi,
	output logic               rx_ready,
	output logic               exec_valid,
	output gmp_hidx_type       exec_hdr,
	output logic               exec_query,
	output logic [31:0]        exec_value,
	output logic [31:0]        exec_word,
	output logic               exec_link,
	output logic [3:0]         exec_nargs,
	input  wire logic          exec_ready,
	output logic               argb_valid,
	output logic [7:0]         argb_data,
	output logic               argb_blk,
	output logic               err_valid,
	output logic [2:0]         err_code,
	input  wire logic          resp_valid,
	input  wire logic [7:0]    resp_data,
	input  wire logic          resp_last,
	output logic               resp_ready,
	output logic               tx_valid,
	output logic [7:0]         tx_data,
	output logic               tx_eoi,
	input  wire logic          tx_ready
);
	localparam int AW = $clog2(OBUF_DEPTH);

	if (OBUF_DEPTH < 2 || (OBUF_DEPTH & (OBUF_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("OBUF_DEPTH must be a power of two of at least 2");
	end

	typedef enum logic [3:0] {
		P_HDR_PRE, P_HDR, P_ARG_PRE, P_NUM, P_WORD, P_ARG_POST, P_STR,
		P_BLK_CNT, P_BLK_DATA, P_SKIP, P_DONE, P_NORM, P_EXEC
	} gmp_pst_type;

	typedef struct packed {
		gmp_pst_type        state;
		logic [1:0]         s_term;
		logic [1:0]         s_loc;
		logic               hdr_seen;
		logic               q;
		logic               link;
		logic [3:0]         nargs;
		logic [31:0]        word;
		gmp_hidx_type       hdr;
		logic [31:0]        mant;
		logic               neg;
		logic               in_frac;
		logic               in_exp;
		logic               edig;
		logic               exp_neg;
		logic               have_num;
		logic               num_err;
		logic               rnd;
		logic [7:0]         expv;
		logic [7:0]         frac;
		logic signed [8:0]  e;
		logic [31:0]        val;
		logic [15:0]        bcnt;
		logic [7:0]         bsum;
		logic               bhi;
		logic               msg_open;
		logic               rx_ready;
		logic               exec_valid;
		logic               argb_valid;
		logic [7:0]         argb_data;
		logic               argb_blk;
		logic               err_valid;
		logic [2:0]         err_code;
		logic [AW-1:0]      wr;
		logic [AW-1:0]      rd;
		logic [AW:0]        cnt;
		logic               ovf;
		logic               sep;
		logic               resp_ready;
		logic               tx_valid;
		logic [7:0]         tx_data;
		logic               tx_eoi;
		logic               lf_pend;
		logic               sent;
	} gmp_st_type;

	gmp_st_type    r_reg;
	gmp_st_type    r_next;
	logic [7:0]    obuf [OBUF_DEPTH];
	logic          ob_we;
	logic [7:0]    ob_wd;
	logic          hm_clear;
	logic          hm_feed;
	logic          hm_hit;
	gmp_hidx_type  hm_idx;

	gmp_hdr_match i_gmp_hdr_match (
		.clk        (clk),
		.srst       (srst),
		.clear      (hm_clear),
		.char_valid (hm_feed),
		.char_in    (rx_data),
		.hit        (hm_hit),
		.hit_idx    (hm_idx)
	);

	always_comb begin
		logic [7:0]         b;
		logic               take;
		logic               term;
		logic               ws;
		logic               dl;
		logic               raw;
		logic               fin;
		logic               rd_en;
		logic               last;
		logic               clr_in;
		logic [2:0]         ecode;
		logic [35:0]        m10;
		logic signed [33:0] sv;
		b = rx_data;
		r_next = r_reg;
		ecode = ERR_NONE;
		hm_feed = 1'b0;
		hm_clear = 1'b0;
		rd_en = 1'b0;
		last = 1'b0;
		m10 = '0;
		sv = '0;
		ob_we = 1'b0;
		ob_wd = resp_data;
		r_next.s_term = {r_reg.s_term[0], term_sel_lf};
		r_next.s_loc = {r_reg.s_loc[0], local_lock};
		r_next.err_valid = 1'b0;
		r_next.argb_valid = 1'b0;
		take = rx_valid && r_reg.rx_ready;
		term = r_reg.s_term[1] ? (b == CH_LF) : rx_eoi;
		ws = (b == CH_SP) || (b == CH_CR) || (b == CH_LF);
		dl = (b == CH_SEMI) || term;
		raw = r_reg.state inside {P_STR, P_BLK_CNT, P_BLK_DATA};
		if (r_reg.state == P_STR) begin
			fin = term;
		end else if (raw) begin
			fin = rx_eoi && !r_reg.s_term[1];
		end else begin
			fin = dl;
		end
		clr_in = dcl || (sdc && listen);

		if (take) begin
			case (r_reg.state)
				P_HDR_PRE: begin
					if (is_letter(b)) begin
						hm_feed = 1'b1;
						r_next.hdr_seen = 1'b1;
						r_next.state = P_HDR;
					end else if (!(ws || dl)) begin
						ecode = ERR_SYNTAX;
					end
				end
				P_HDR: begin
					if (is_letter(b) && !r_reg.q) begin
						hm_feed = 1'b1;
					end else if (b == CH_QMARK && !r_reg.q) begin
						r_next.q = 1'b1;
					end else if (b == CH_SP) begin
						r_next.state = P_ARG_PRE;
					end else if (ws && !term) begin
						r_next.state = P_ARG_POST;
					end else if (!dl) begin
						ecode = ERR_SYNTAX;
					end
				end
				P_ARG_PRE: begin
					if (is_digit(b) || b == CH_PLUS || b == CH_MINUS || b == CH_DOT) begin
						r_next.mant = is_digit(b) ? {28'h0, b[3:0]} : 32'h0;
						r_next.neg = (b == CH_MINUS);
						r_next.in_frac = (b == CH_DOT);
						r_next.in_exp = 1'b0;
						r_next.edig = 1'b0;
						r_next.exp_neg = 1'b0;
						r_next.expv = 8'h0;
						r_next.frac = 8'h0;
						r_next.num_err = 1'b0;
						r_next.have_num = 1'b1;
						r_next.state = P_NUM;
					end else if (is_letter(b)) begin
						r_next.word = {24'h0, upcase(b)};
						r_next.state = P_WORD;
					end else if (b == CH_QUOTE) begin
						r_next.state = P_STR;
					end else if (b == CH_PCT) begin
						r_next.bhi = 1'b1;
						r_next.bsum = 8'h0;
						r_next.state = P_BLK_CNT;
					end else if (!(ws || dl)) begin
						ecode = ERR_SYNTAX;
					end
					if (r_next.state != P_ARG_PRE && r_reg.nargs != 4'hf) begin
						r_next.nargs = r_reg.nargs + 4'h1;
					end
				end
				P_NUM: begin
					if (is_digit(b) && r_reg.in_exp) begin
						r_next.edig = 1'b1;
						if (r_reg.expv >= EXP_DIG_MAX) begin
							r_next.num_err = 1'b1;
						end else begin
							r_next.expv = 8'(r_reg.expv * 8'h0a + {4'h0, b[3:0]});
						end
					end else if (is_digit(b)) begin
						m10 = mul10(r_reg.mant) + {32'h0, b[3:0]};
						if (m10[35:32] != 4'h0 || r_reg.frac >= FRAC_MAX) begin
							r_next.num_err = 1'b1;
						end
						r_next.mant = m10[31:0];
						if (r_reg.in_frac) begin
							r_next.frac = r_reg.frac + 8'h1;
						end
					end else if (b == CH_DOT && !r_reg.in_frac && !r_reg.in_exp) begin
						r_next.in_frac = 1'b1;
					end else if (upcase(b) == CH_E && !r_reg.in_exp) begin
						r_next.in_exp = 1'b1;
					end else if ((b == CH_PLUS || b == CH_MINUS) && r_reg.in_exp && !r_reg.edig) begin
						r_next.exp_neg = (b == CH_MINUS);
					end else if (b == CH_COMMA) begin
						r_next.state = P_ARG_PRE;
					end else if (ws && !term) begin
						r_next.state = P_ARG_POST;
					end else if (!dl) begin
						ecode = ERR_SYNTAX;
					end
				end
				P_WORD: begin
					if (is_letter(b) || is_digit(b)) begin
						r_next.word = {r_reg.word[23:0], upcase(b)};
					end else if (b == CH_COLON && !r_reg.link) begin
						r_next.link = 1'b1;
						r_next.state = P_ARG_PRE;
					end else if (b == CH_COMMA) begin
						r_next.state = P_ARG_PRE;
					end else if (ws && !term) begin
						r_next.state = P_ARG_POST;
					end else if (!dl) begin
						ecode = ERR_SYNTAX;
					end
				end
				P_ARG_POST: begin
					if (b == CH_COMMA) begin
						r_next.state = P_ARG_PRE;
					end else if (!(ws || dl)) begin
						ecode = ERR_SYNTAX;
					end
				end
				P_STR: begin
					if (b == CH_QUOTE) begin
						r_next.state = P_ARG_POST;
					end else if (fin) begin
						ecode = ERR_SYNTAX;
					end else begin
						r_next.argb_valid = 1'b1;
						r_next.argb_data = b;
						r_next.argb_blk = 1'b0;
					end
				end
				P_BLK_CNT: begin
					r_next.bsum = r_reg.bsum + b;
					r_next.bhi = 1'b0;
					if (r_reg.bhi) begin
						r_next.bcnt[15:8] = b;
					end else begin
						r_next.bcnt[7:0] = b;
						r_next.state = P_BLK_DATA;
					end
					if (fin || (!r_reg.bhi && r_reg.bcnt[15:8] == 8'h0 && b == 8'h0)) begin
						ecode = ERR_SYNTAX;
					end
				end
				P_BLK_DATA: begin
					r_next.bsum = r_reg.bsum + b;
					r_next.bcnt = r_reg.bcnt - 16'h1;
					if (r_reg.bcnt == 16'h1) begin
						if (8'(r_reg.bsum + b) != 8'h0) begin
							ecode = ERR_CHECKSUM;
						end else begin
							r_next.state = P_ARG_POST;
						end
					end else begin
						r_next.argb_valid = 1'b1;
						r_next.argb_data = b;
						r_next.argb_blk = 1'b1;
						if (fin) begin
							ecode = ERR_SYNTAX;
						end
					end
				end
				default: ;
			endcase
			if (ecode != ERR_NONE) begin
				r_next.err_valid = 1'b1;
				r_next.err_code = ecode;
				r_next.state = fin ? P_HDR_PRE : P_SKIP;
			end else if (fin) begin
				r_next.state = (r_reg.state == P_SKIP) ? P_HDR_PRE : P_DONE;
			end
			r_next.msg_open = raw ? !fin : !term;
		end

		// decode, numeric scaling and hand-off run with input stalled
		case (r_reg.state)
			P_DONE: begin
				if (!r_reg.hdr_seen) begin
					r_next.state = P_HDR_PRE;
				end else if (!hm_hit) begin
					r_next.err_valid = 1'b1;
					r_next.err_code = ERR_HEADER;
					r_next.state = P_HDR_PRE;
				end else begin
					r_next.hdr = hm_idx;
					r_next.rnd = 1'b0;
					r_next.e = (r_reg.exp_neg ? -$signed({1'b0, r_reg.expv})
						: $signed({1'b0, r_reg.expv})) - $signed({1'b0, r_reg.frac});
					r_next.state = P_NORM;
				end
			end
			P_NORM: begin
				if (!r_reg.have_num) begin
					r_next.state = P_EXEC;
				end else if (r_reg.num_err) begin
					r_next.err_valid = 1'b1;
					r_next.err_code = ERR_RANGE;
					r_next.state = P_HDR_PRE;
				end else if (r_reg.e != 9'sh0 && r_reg.mant == 32'h0) begin
					r_next.e = 9'sh0;
				end else if (r_reg.e > 9'sh0) begin
					m10 = mul10(r_reg.mant);
					r_next.num_err = (m10[35:32] != 4'h0);
					r_next.mant = m10[31:0];
					r_next.e = r_reg.e - 9'sh1;
				end else if (r_reg.e < 9'sh0) begin
					r_next.rnd = r_reg.rnd || (r_reg.mant % 32'h0a != 32'h0);
					r_next.mant = r_reg.mant / 32'h0a;
					r_next.e = r_reg.e + 9'sh1;
				end else begin
					sv = r_reg.neg ? -($signed({2'b0, r_reg.mant}) + $signed({33'h0, r_reg.rnd}))
						: $signed({2'b0, r_reg.mant});
					if (sv < $signed(HDR_LO[r_reg.hdr]) || sv > $signed(HDR_HI[r_reg.hdr])) begin
						r_next.err_valid = 1'b1;
						r_next.err_code = ERR_RANGE;
						r_next.state = P_HDR_PRE;
					end else begin
						r_next.val = sv[31:0];
						r_next.state = P_EXEC;
					end
				end
			end
			P_EXEC: begin
				if (!r_reg.exec_valid && r_reg.s_loc[1] && HDR_LOCAL[r_reg.hdr]) begin
					r_next.state = P_HDR_PRE;
				end else if (!r_reg.exec_valid) begin
					r_next.exec_valid = 1'b1;
				end else if (exec_ready) begin
					r_next.exec_valid = 1'b0;
					r_next.state = P_HDR_PRE;
				end
			end
			default: ;
		endcase

		if (clr_in && r_reg.state != P_EXEC) begin
			r_next.state = P_HDR_PRE;
		end
		if (r_next.state == P_HDR_PRE && r_reg.state != P_HDR_PRE) begin
			hm_clear = 1'b1;
			r_next.hdr_seen = 1'b0;
			r_next.q = 1'b0;
			r_next.link = 1'b0;
			r_next.nargs = 4'h0;
			r_next.word = 32'h0;
			r_next.have_num = 1'b0;
			r_next.num_err = 1'b0;
		end
		r_next.rx_ready = !(r_next.state inside {P_DONE, P_NORM, P_EXEC});

		// response buffer fill
		if (resp_valid && r_reg.sep) begin
			ob_we = 1'b1;
			ob_wd = CH_SEMI;
			r_next.sep = 1'b0;
		end else if (resp_valid && r_reg.resp_ready) begin
			ob_we = 1'b1;
			r_next.sep = resp_last;
		end
		if (ob_we && (r_reg.ovf || r_reg.cnt == (AW + 1)'(OBUF_DEPTH))) begin
			ob_we = 1'b0;
			r_next.ovf = 1'b1;
		end
		r_next.resp_ready = !r_next.sep;

		// transmit side
		if (r_reg.tx_valid && tx_ready) begin
			r_next.tx_valid = 1'b0;
		end
		if (unt || ifc || dcl) begin
			r_next.tx_valid = 1'b0;
			r_next.lf_pend = 1'b0;
		end else if (talk && (!r_reg.tx_valid || tx_ready)) begin
			if (r_reg.lf_pend) begin
				r_next.tx_valid = 1'b1;
				r_next.tx_data = CH_LF;
				r_next.tx_eoi = 1'b0;
				r_next.lf_pend = 1'b0;
			end else if (r_reg.cnt != '0) begin
				rd_en = 1'b1;
				last = (r_reg.cnt == (AW + 1)'(1)) && !ob_we;
				r_next.tx_valid = 1'b1;
				r_next.tx_data = obuf[r_reg.rd];
				r_next.tx_eoi = last && !r_reg.s_term[1];
				r_next.lf_pend = last && r_reg.s_term[1];
				r_next.sent = 1'b1;
			end else if (!r_reg.sent) begin
				r_next.tx_valid = 1'b1;
				r_next.tx_data = CH_ONES;
				r_next.tx_eoi = 1'b1;
				r_next.sent = 1'b1;
			end
		end
		if (!talk) begin
			r_next.sent = 1'b0;
		end

		r_next.wr = r_reg.wr + AW'(ob_we);
		r_next.rd = r_reg.rd + AW'(rd_en);
		r_next.cnt = r_reg.cnt + (AW + 1)'(ob_we) - (AW + 1)'(rd_en);
		if (clr_in || (take && listen && !r_reg.msg_open)) begin
			ob_we = 1'b0;
			r_next.wr = '0;
			r_next.rd = '0;
			r_next.cnt = '0;
			r_next.ovf = 1'b0;
			r_next.sep = 1'b0;
			r_next.resp_ready = 1'b1;
			r_next.lf_pend = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	always_ff @(posedge clk) begin
		if (ob_we) begin
			obuf[r_reg.wr] <= ob_wd;
		end
	end

	assign rx_ready   = r_reg.rx_ready;
	assign exec_valid = r_reg.exec_valid;
	assign exec_hdr   = r_reg.hdr;
	assign exec_query = r_reg.q;
	assign exec_value = r_reg.val;
	assign exec_word  = r_reg.word;
	assign exec_link  = r_reg.link;
	assign exec_nargs = r_reg.nargs;
	assign argb_valid = r_reg.argb_valid;
	assign argb_data  = r_reg.argb_data;
	assign argb_blk   = r_reg.argb_blk;
	assign err_valid  = r_reg.err_valid;
	assign err_code   = r_reg.err_code;
	assign resp_ready = r_reg.resp_ready;
	assign tx_valid   = r_reg.tx_valid;
	assign tx_data    = r_reg.tx_data;
	assign tx_eoi     = r_reg.tx_eoi;
endmodule // gmp_parser
`default_nettype wire

/* File: verification/gmp_parser_checker.sv */
// port assertions for the message parser
`timescale 1ns/100ps
`default_nettype none
module gmp_parser_checker
	import gmp_pkg::*;
(
	input wire logic         clk,
	input wire logic         srst,
	input wire logic         term_sel_lf,
	input wire logic         rx_valid,
	input wire logic [7:0]   rx_data,
	input wire logic         rx_ready,
	input wire logic         exec_valid,
	input wire gmp_hidx_type exec_hdr,
	input wire logic [31:0]  exec_value,
	input wire logic         exec_ready,
	input wire logic         err_valid,
	input wire logic [2:0]   err_code,
	input wire logic         resp_valid,
	input wire logic         resp_last,
	input wire logic         resp_ready,
	input wire logic         tx_valid,
	input wire logic [7:0]   tx_data,
	input wire logic         tx_eoi,
	input wire logic         tx_ready,
	input wire logic         dcl,
	input wire logic         unt,
	input wire logic         ifc
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	chk_unit_wait: assert property (rx_valid && rx_ready && rx_data == CH_SEMI |=> !rx_ready)
		else $error("no wait at unit end");
	chk_exec_gated: assert property ($rose(exec_valid) |-> !rx_ready && !$past(rx_ready))
		else $error("early hand-off");
	chk_exec_hold: assert property (exec_valid && !exec_ready |=> exec_valid && $stable(exec_hdr) && $stable(exec_value))
		else $error("unit changed");
	chk_mode_range: assert property (exec_valid && exec_hdr == 3'h0 |-> exec_value <= 32'h3)
		else $error("mode out of range");
	chk_err_code: assert property (err_valid |-> err_code != ERR_NONE && err_code <= ERR_CHECKSUM)
		else $error("bad error code");
	chk_tx_hold: assert property (tx_valid && !tx_ready && !(unt || ifc || dcl) |=> tx_valid && $stable(tx_data) && $stable(tx_eoi))
		else $error("byte not held");
	chk_resp_pause: assert property (resp_valid && resp_ready && resp_last |=> !resp_ready)
		else $error("no unit pause");
	chk_lf_end: assert property (tx_valid && tx_eoi && term_sel_lf && $past(term_sel_lf, 3) |-> tx_data == CH_ONES)
		else $error("eoi in lf mode");
endmodule // gmp_parser_checker
bind gmp_parser gmp_parser_checker i_gmp_parser_checker (.clk(clk), .srst(srst),
	.term_sel_lf(term_sel_lf), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
	.exec_valid(exec_valid), .exec_hdr(exec_hdr), .exec_value(exec_value),
	.exec_ready(exec_ready), .err_valid(err_valid), .err_code(err_code),
	.resp_valid(resp_valid), .resp_last(resp_last), .resp_ready(resp_ready),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_ready(tx_ready),
	.dcl(dcl), .unt(unt), .ifc(ifc));
`default_nettype wire

/* File: verification/gmp_ctrl_model.sv */
// bus controller model: sends command bytes and reads talked bytes
`timescale 1ns/100ps
`default_nettype none
module gmp_ctrl_model (
	input  wire logic       clk,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_eoi,
	input  wire logic       rx_ready,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_eoi,
	output logic            tx_ready
);
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_eoi = 1'b0;
		tx_ready = 1'b0;
	end
	// byte held until taken
	task automatic send(input logic [7:0] b, input logic e);
		rx_valid = 1'b1;
		rx_data = b;
		rx_eoi = e;
		for (int i = 0; i < 300; i++) begin
			@(posedge clk);
			if (rx_ready)
				break;
		end
		#1;
	endtask
	// released bus shows no stale byte
	task automatic idle;
		rx_valid = 1'b0;
		rx_eoi = 1'b0;
		rx_data = ~rx_data;
	endtask
	task automatic msg(input string s, input logic e);
		for (int i = 0; i < s.len(); i++)
			send(s[i], e && i == s.len() - 1);
		idle();
	endtask
	// ready held from here on
	task automatic get(output logic [7:0] d, output logic e);
		tx_ready = 1'b1;
		for (int i = 0; i < 300; i++) begin
			@(posedge clk);
			if (tx_valid)
				break;
		end
		d = tx_data;
		e = tx_eoi;
		#1;
	endtask
endmodule // gmp_ctrl_model
`default_nettype wire

/* File: verification/tb_gmp_parser.sv */
// testbench for the message parser
`timescale 1ns/100ps
`default_nettype none
module tb_gmp_parser;
	logic clk, srst, term_sel_lf, local_lock, listen, talk, dcl, sdc, unt, ifc;
	logic rx_valid, rx_eoi, rx_ready, exec_valid, exec_query, exec_link, exec_ready;
	logic argb_valid, argb_blk, err_valid, resp_valid, resp_last, resp_ready;
	logic tx_valid, tx_eoi, tx_ready, e;
	logic [7:0] rx_data, argb_data, resp_data, tx_data, d;
	logic [2:0] exec_hdr, err_code;
	logic [31:0] exec_value, exec_word, eq[$], erq[$], aq[$];
	logic [3:0] exec_nargs;
	int mismatches = 0, total_checks = 0, cycles = 0;
	gmp_parser #(.OBUF_DEPTH(8)) i_gmp_parser (.clk(clk), .srst(srst),
		.term_sel_lf(term_sel_lf), .local_lock(local_lock), .listen(listen), .talk(talk),
		.dcl(dcl), .sdc(sdc), .unt(unt), .ifc(ifc), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_eoi(rx_eoi), .rx_ready(rx_ready), .exec_valid(exec_valid), .exec_hdr(exec_hdr),
		.exec_query(exec_query), .exec_value(exec_value), .exec_word(exec_word),
		.exec_link(exec_link), .exec_nargs(exec_nargs), .exec_ready(exec_ready),
		.argb_valid(argb_valid), .argb_data(argb_data), .argb_blk(argb_blk),
		.err_valid(err_valid), .err_code(err_code), .resp_valid(resp_valid),
		.resp_data(resp_data), .resp_last(resp_last), .resp_ready(resp_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_ready(tx_ready));
	gmp_ctrl_model i_gmp_ctrl_model (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_eoi(rx_eoi), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_eoi(tx_eoi), .tx_ready(tx_ready));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			results();
		end
		if (exec_valid && exec_ready)
			eq.push_back({exec_word[15:0], 7'h0, exec_query, exec_link, exec_nargs, exec_hdr});
		if (exec_valid && exec_ready)
			eq.push_back(exec_value);
		if (err_valid)
			erq.push_back({29'h0, err_code});
		if (argb_valid)
			aq.push_back({23'h0, argb_blk, argb_data});
	end
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", n, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic settle;
		for (int i = 0; i < 300 && rx_ready !== 1'b1; i++)
			@(posedge clk);
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic put(input logic [7:0] b, input logic l);
		resp_valid = 1'b1;
		resp_data = b;
		resp_last = l;
		for (int i = 0; i < 300; i++) begin
			@(posedge clk);
			if (resp_ready)
				break;
		end
		#1;
	endtask
	task automatic t_units;
		i_gmp_ctrl_model.msg("mode 2;LEV -3.7;level 25E-1;", 1'b1);
		settle();
		chk("units", eq.size(), 6);
		chk("hdr0", eq.pop_front(), 32'h8);
		chk("val0", eq.pop_front(), 32'h2);
		chk("hdr1", eq.pop_front(), 32'h9);
		chk("val1", eq.pop_front(), 32'hffff_fffc);
		chk("hdr2", eq.pop_front(), 32'h9);
		chk("val2", eq.pop_front(), 32'h2);
		i_gmp_ctrl_model.msg("setup? on:0;MODE 9;XYZ 1", 1'b1);
		settle();
		chk("range", eq.size(), 2);
		chk("err0", erq.pop_front(), 32'h3);
		chk("err1", erq.pop_front(), 32'h1);
		chk("link", eq.pop_front(), 32'h4f4e_0193);
		eq.delete();
		local_lock = 1'b1;
		settle();
		i_gmp_ctrl_model.msg("MODE 1;TEXT \"ab\"", 1'b1);
		settle();
		chk("local", eq.size(), 2);
		chk("text", eq.pop_front(), 32'ha);
		chk("str", {aq[0][15:0], aq[1][15:0]}, 32'h0061_0062);
		local_lock = 1'b0;
	endtask
	task automatic t_block;
		logic [7:0] b[12];
		b = '{8'h43, 8'h55, 8'h52, 8'h56, 8'h45, 8'h20, 8'h25, 8'h00, 8'h03, 8'h11, 8'h22, 8'hca};
		for (int k = 0; k < 2; k++) begin
			erq.delete();
			aq.delete();
			b[11] = 8'hca + 8'(k);
			for (int i = 0; i < 12; i++)
				i_gmp_ctrl_model.send(b[i], i == 11);
			i_gmp_ctrl_model.idle();
			settle();
			chk("blk_err", erq.size(), k);
			chk("blk_n", aq.size(), 2);
			chk("blk_b1", aq[1], 32'h122);
		end
		chk("blk_code", erq.pop_front(), 32'h4);
	endtask
	task automatic t_output;
		put(8'h41, 1'b1);
		put(8'h42, 1'b1);
		resp_valid = 1'b0;
		talk = 1'b1;
		for (int k = 0; k < 3; k++) begin
			i_gmp_ctrl_model.get(d, e);
			chk("tx", {e, d}, {k == 2, k == 0 ? 8'h41 : k == 1 ? 8'h3b : 8'h42});
		end
		talk = 1'b0;
		put(8'h44, 1'b1);
		resp_valid = 1'b0;
		dcl = 1'b1;
		@(posedge clk);
		#1;
		dcl = 1'b0;
		talk = 1'b1;
		i_gmp_ctrl_model.get(d, e);
		chk("empty", {e, d}, 9'h1ff);
		talk = 1'b0;
		term_sel_lf = 1'b1;
		settle();
		eq.delete();
		i_gmp_ctrl_model.msg("MODE 1\n", 1'b0);
		settle();
		chk("lfterm", eq.size(), 2);
		for (int i = 0; i < 9; i++)
			put(8'h43, 1'b0);
		resp_valid = 1'b0;
		talk = 1'b1;
		i_gmp_ctrl_model.get(d, e);
		chk("lf0", {e, d}, 9'h043);
		for (int k = 1; k < 9; k++) begin
			i_gmp_ctrl_model.get(d, e);
			chk("lf1", {e, d}, k == 8 ? 9'h00a : 9'h043);
		end
		talk = 1'b0;
	endtask
	initial begin
		{srst, term_sel_lf, local_lock, listen, talk, dcl, sdc, unt, ifc} = 9'h100;
		{exec_ready, resp_valid, resp_data, resp_last} = 11'h400;
		repeat (8) @(posedge clk);
		#1;
		srst = 1'b0;
		t_units();
		t_block();
		t_output();
		results();
	end
endmodule // tb_gmp_parser
`default_nettype wire
